// File: rtl/twe_core.v
// Purpose: Command decode and control of a three-wire serial memory
// Assumes: ref_clk 10 MHz, serial_clock far slower and sampled here
// Notes:   Self-timed program cycle counted in ref_clk cycles
`include "twe_defines.vh"
module twe_core #(
  parameter PROG_US = `TWE_PROG_TIME_US,
  parameter POR_US  = `TWE_POR_TIME_US
) (
  input  wire ref_clk,
  input  wire rst,
  input  wire chip_select,
  input  wire serial_clock,
  input  wire serial_in,
  input  wire org_select,
  output reg  serial_out,
  output reg  serial_out_oe_n,
  output reg  prog_busy,
  output reg  write_enabled
);
  localparam AW         = 10;
  localparam PROG_CYC   = PROG_US * `TWE_CLK_MHZ;
  localparam POR_CYC    = (POR_US * `TWE_CLK_MHZ < 1) ? 1 : POR_US * `TWE_CLK_MHZ;
  localparam ST_IDLE    = 3'h0;
  localparam ST_CMD     = 3'h1;
  localparam ST_ADDR    = 3'h2;
  localparam ST_DATA    = 3'h3;
  localparam ST_READ    = 3'h4;
  localparam ST_STATUS  = 3'h5;
  localparam ST_DONE    = 3'h6;

  wire [3:0] pins_sync;
  reg        sk_prev;
  reg        cs_prev;
  reg  [2:0] state;
  reg  [1:0] opcode;
  reg  [3:0] bit_cnt;
  reg  [AW:0] addr;
  reg  [15:0] data_sr;
  reg  [15:0] out_sr;
  reg        byte_mode;
  reg  [23:0] prog_cnt;
  reg  [15:0] por_cnt;
  reg        por_done;
  reg        wr_one;
  reg        wr_all;
  reg  [15:0] wr_data;
  reg        busy_poll;
  wire [15:0] rd_data;

  wire org_s = pins_sync[3];
  wire cs_s  = pins_sync[2];
  wire sk_s  = pins_sync[1];
  wire di_s  = pins_sync[0];
  wire sk_rise = sk_s & ~sk_prev;
  wire cs_rise = cs_s & ~cs_prev;
  wire [3:0] addr_last = byte_mode ? `TWE_ADDR_LAST_X8 : `TWE_ADDR_LAST_X16;
  wire [3:0] data_last = byte_mode ? `TWE_DATA_LAST_X8 : `TWE_DATA_LAST_X16;
  wire [1:0] sub_op = byte_mode ? addr[10:9] : addr[9:8];

  // Decodes whether an opcode programs the array
  function is_prog;
    input [1:0] op;
    input [1:0] sub;
    begin
      is_prog = (op == `TWE_OP_ERASE) || (op == `TWE_OP_WRITE) ||
                ((op == `TWE_OP_SPECIAL) &&
                 (sub == `TWE_SUB_ERALL || sub == `TWE_SUB_WRALL));
    end
  endfunction

  twe_sync #(
    .WIDTH (4)
  ) u_sync (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .pin_in   ({org_select, chip_select, serial_clock, serial_in}),
    .pin_sync (pins_sync)
  );

  twe_memory #(
    .WORDS (`TWE_WORDS),
    .AW    (AW)
  ) u_mem (
    .ref_clk   (ref_clk),
    .wr_one    (wr_one),
    .wr_all    (wr_all),
    .byte_mode (byte_mode),
    .wr_addr   (addr),
    .wr_data   (wr_data),
    .rd_addr   (addr),
    .rd_data   (rd_data)
  );

  // Edge history of the synchronised pins
  always @(posedge ref_clk) begin
    if (rst) begin
      sk_prev <= 1'b0;
      cs_prev <= 1'b0;
    end else begin
      sk_prev <= sk_s;
      cs_prev <= cs_s;
    end
  end

  // Power-on hold-off
  // Stands in for the supply threshold; rst models power removal
  always @(posedge ref_clk) begin
    if (rst) begin
      por_cnt  <= 16'h0000;
      por_done <= 1'b0;
    end else if (!por_done) begin
      por_cnt  <= por_cnt + 16'h0001;
      por_done <= (por_cnt == POR_CYC[15:0] - 16'h0001);
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      prog_cnt  <= 24'h00_0000;
      prog_busy <= 1'b0;
    end else if (wr_one || wr_all) begin
      prog_cnt  <= PROG_CYC[23:0];
      prog_busy <= 1'b1;
    end else if (prog_busy) begin
      prog_cnt  <= prog_cnt - 24'h00_0001;
      prog_busy <= (prog_cnt != 24'h00_0001);
    end
  end

  // Main instruction sequencer
  always @(posedge ref_clk) begin
    if (rst) begin
      state           <= ST_IDLE;
      opcode          <= 2'h0;
      bit_cnt         <= 4'h0;
      addr            <= {(AW+1){1'b0}};
      data_sr         <= 16'h0000;
      out_sr          <= 16'h0000;
      byte_mode       <= 1'b0;
      write_enabled   <= 1'b0;       // Starts disabled
      wr_one          <= 1'b0;
      wr_all          <= 1'b0;
      wr_data         <= 16'h0000;
      busy_poll       <= 1'b0;
      serial_out      <= 1'b0;
      serial_out_oe_n <= 1'b1;
    end else begin
      wr_one <= 1'b0;
      wr_all <= 1'b0;
      if (!cs_s) begin
        // Select low releases output and resets decode
        state           <= ST_IDLE;
        serial_out_oe_n <= 1'b1;
        serial_out      <= 1'b0;
      end else begin
        case (state)
          ST_IDLE: begin
            // New instruction only after a select rise
            // Status only when busy at the select rise
            if (cs_rise && por_done) begin
              byte_mode <= ~org_s;        // Organisation latched
              if (busy_poll && prog_busy) begin
                state           <= ST_STATUS;
                serial_out      <= 1'b0;
                serial_out_oe_n <= 1'b0;
              end else begin
                busy_poll <= 1'b0;
                state     <= ST_CMD;
                bit_cnt   <= 4'h0;
              end
            end
          end
          ST_CMD: begin
            // Wait for start bit, then two opcode bits
            if (sk_rise && !prog_busy) begin
              if (bit_cnt == 4'h0) begin
                bit_cnt <= di_s ? 4'h1 : 4'h0;
              end else begin
                opcode  <= {opcode[0], di_s};
                bit_cnt <= bit_cnt + 4'h1;
                if (bit_cnt == `TWE_CMD_BITS - 1) begin
                  state   <= ST_ADDR;
                  bit_cnt <= 4'h0;
                end
              end
            end
          end
          ST_ADDR: begin
            // Every address bit, don't-care included, is shifted
            if (sk_rise) begin
              addr    <= {addr[AW-1:0], di_s};
              bit_cnt <= bit_cnt + 4'h1;
              if (bit_cnt == addr_last) begin
                bit_cnt <= 4'h0;
                state   <= ST_DONE;
                if (opcode == `TWE_OP_READ) begin
                  state <= ST_READ;
                end else if (opcode == `TWE_OP_WRITE) begin
                  state <= ST_DATA;
                end else if (opcode == `TWE_OP_ERASE) begin
                  wr_data   <= `TWE_ERASED_WORD;
                  wr_one    <= write_enabled;
                  busy_poll <= write_enabled;
                end
              end
            end
          end
          ST_DATA: begin
            // Collect data word after the address
            if (sk_rise) begin
              data_sr <= {data_sr[14:0], di_s};
              bit_cnt <= bit_cnt + 4'h1;
              if (bit_cnt == data_last) begin
                // Program starts after last data bit
                wr_data   <= {data_sr[14:0], di_s};
                wr_one    <= write_enabled && (opcode == `TWE_OP_WRITE);
                wr_all    <= write_enabled && (opcode == `TWE_OP_SPECIAL);
                busy_poll <= write_enabled;
                state     <= ST_DONE;
                // Done mark, else a wrapped count re-arms write-all
                bit_cnt   <= 4'h1;
              end
            end
          end
          ST_READ: begin
            // Output moves on clock rise only
            if (sk_rise) begin
              serial_out_oe_n <= 1'b0;
              if (serial_out_oe_n) begin
                serial_out <= 1'b0;    // Leading zero
                out_sr     <= byte_mode ? {rd_data[7:0], 8'h00} : rd_data;
                bit_cnt    <= 4'h0;
              end else begin
                serial_out <= out_sr[15];
                out_sr     <= {out_sr[14:0], 1'b0};
                bit_cnt    <= bit_cnt + 4'h1;
                if (bit_cnt == data_last) begin
                  addr    <= addr + {{AW{1'b0}}, 1'b1};
                  bit_cnt <= 4'h0;
                end
              end
            end else if (!serial_out_oe_n && bit_cnt == 4'h0 && sk_prev) begin
              // Refill after wrap, before the next rise
              out_sr <= byte_mode ? {rd_data[7:0], 8'h00} : rd_data;
            end
          end
          ST_STATUS: begin
            // Low while busy, high once ready
            serial_out <= ~prog_busy;
            if (!prog_busy) begin
              busy_poll <= 1'b0;
            end
          end
          ST_DONE: begin
            // Wait for select to drop; special ops act once here
            if (opcode == `TWE_OP_SPECIAL && bit_cnt == 4'h0) begin
              bit_cnt <= 4'h1;
              if (sub_op == `TWE_SUB_ENABLE) begin
                write_enabled <= 1'b1;
              end else if (sub_op == `TWE_SUB_DISABLE) begin
                write_enabled <= 1'b0;
              end else if (sub_op == `TWE_SUB_ERALL) begin
                wr_data   <= `TWE_ERASED_WORD;
                wr_all    <= write_enabled;
                busy_poll <= write_enabled;
              end else if (is_prog(opcode, sub_op)) begin
                // Write-all needs its data word first
                state   <= ST_DATA;
                bit_cnt <= 4'h0;
              end
            end
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end
endmodule

// File: rtl/twe_defines.vh
// Purpose: Shared constants of the three-wire serial memory command logic
// Assumes: Included by bare name from the core, memory and testbench files; the synchroniser, checker and host do not include it
// Notes:   Definitions only
`ifndef TWE_DEFINES_VH
`define TWE_DEFINES_VH
`define TWE_OP_SPECIAL   2'h0
`define TWE_OP_WRITE     2'h1
`define TWE_OP_READ      2'h2
`define TWE_OP_ERASE     2'h3
`define TWE_SUB_DISABLE  2'h0
`define TWE_SUB_WRALL    2'h1
`define TWE_SUB_ERALL    2'h2
`define TWE_SUB_ENABLE   2'h3
`define TWE_CMD_BITS     3
`define TWE_ADDR_LAST_X8  4'hA
`define TWE_ADDR_LAST_X16 4'h9
`define TWE_DATA_LAST_X8  4'h7
`define TWE_DATA_LAST_X16 4'hF
`define TWE_WORDS        1024
`define TWE_ERASED_WORD  16'hFFFF
`define TWE_PROG_TIME_US 3000
`define TWE_CLK_MHZ      10
`define TWE_POR_TIME_US  1
`endif

// File: rtl/twe_memory.v
// Purpose: Word storage array with single-word and whole-array program
// Assumes: One program request at a time, array sized for 16-bit words
// Notes:   Byte mode uses the low or high half selected by address bit 0
`include "twe_defines.vh"
module twe_memory #(
  parameter WORDS = 1024,
  parameter AW    = 10
) (
  input  wire          ref_clk,
  input  wire          wr_one,
  input  wire          wr_all,
  input  wire          byte_mode,
  input  wire [AW:0]   wr_addr,
  input  wire [15:0]   wr_data,
  input  wire [AW:0]   rd_addr,
  output wire [15:0]   rd_data
);
  reg [15:0] mem [0:WORDS-1];
  integer    i;

  wire [15:0] rd_word = byte_mode ? mem[rd_addr[AW:1]] : mem[rd_addr[AW-1:0]];
  assign rd_data = byte_mode ? {8'h00, (rd_addr[0] ? rd_word[15:8] : rd_word[7:0])}
                             : rd_word;

  // Program one location or the whole array
  always @(posedge ref_clk) begin
    if (wr_all) begin
      for (i = 0; i < WORDS; i = i + 1) begin
        mem[i] <= byte_mode ? {wr_data[7:0], wr_data[7:0]} : wr_data;
      end
    end else if (wr_one) begin
      if (!byte_mode) begin
        mem[wr_addr[AW-1:0]] <= wr_data;
      end else if (wr_addr[0]) begin
        mem[wr_addr[AW:1]][15:8] <= wr_data[7:0];
      end else begin
        mem[wr_addr[AW:1]][7:0] <= wr_data[7:0];
      end
    end
  end
endmodule

// File: rtl/twe_sync.v
// Purpose: Two-flop synchroniser for pins from outside the clock domain
// Assumes: Synchronous active-high reset
// Notes:   First stage is read by the second stage only
module twe_sync #(
  parameter WIDTH = 1
) (
  input  wire             ref_clk,
  input  wire             rst,
  input  wire [WIDTH-1:0] pin_in,
  output reg  [WIDTH-1:0] pin_sync
);
  reg [WIDTH-1:0] stage_one;

  // Meta-stability guard on every bit
  always @(posedge ref_clk) begin
    if (rst) begin
      stage_one <= {WIDTH{1'b0}};
      pin_sync  <= {WIDTH{1'b0}};
    end else begin
      stage_one <= pin_in;
      pin_sync  <= stage_one;
    end
  end
endmodule

// File: tb/testbench.sv
// Purpose: Self-checking bench of the three-wire command logic
// Assumes: Program cycle shortened to 5 us
// Notes:   Released output line shows the inverse of serial_out, which is held low while released, so it reads high
`include "twe_defines.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic rst, org_select, first;
  wire  chip_select, serial_clock, serial_in, serial_out, serial_out_oe_n;
  wire  prog_busy, write_enabled, data_line;
  logic [63:0] rx;
  int errors, checks_done, waited;
  // Rows: word address and data; reads expect each row then the next
  logic [25:0] rows [4] = '{{10'h000, 16'hA5C3}, {10'h001, 16'h0F0F},
                           {10'h002, 16'h8001}, {10'h003, 16'h7E18}};
  always #50 ref_clk = ~ref_clk;
  assign data_line = serial_out_oe_n ? ~serial_out : serial_out;
  twe_core #(.PROG_US(5), .POR_US(1)) u_twe_core (
    .ref_clk(ref_clk), .rst(rst), .chip_select(chip_select), .serial_clock(serial_clock),
    .serial_in(serial_in), .org_select(org_select), .serial_out(serial_out),
    .serial_out_oe_n(serial_out_oe_n), .prog_busy(prog_busy), .write_enabled(write_enabled)
  );
  twe_host u_twe_host (
    .ref_clk(ref_clk), .data_line(data_line), .chip_select(chip_select),
    .serial_clock(serial_clock), .serial_in(serial_in)
  );
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    if (errors == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // One frame, then a status poll when ready is set
  task automatic run(input logic [63:0] bits, input int n, input logic ready);
    u_twe_host.frame(bits, n, rx);
    if (ready) begin
      u_twe_host.poll(first, waited);
      chk(first, 1'b0);
      chk(waited < 300, 1'b1);
      if (waited >= 300) wrap_up();
    end
  endtask
  task automatic special(input logic [1:0] sub);
    run({1'b1, `TWE_OP_SPECIAL, sub, 8'h00}, 13, sub == `TWE_SUB_ERALL);
  endtask
  initial begin
    rst = 1'b1;
    org_select = 1'b1;
    errors = 0;
    checks_done = 0;
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    @(negedge ref_clk);
    chk(write_enabled, 1'b0);
    chk(prog_busy, 1'b0);
    chk(serial_out_oe_n, 1'b1);
    // Host waits out the power-up delay first
    repeat (1000) @(posedge ref_clk);
    run({1'b1, `TWE_OP_WRITE, 10'h000, 16'h1234}, 29, 1'b0);
    chk(prog_busy, 1'b0);
    special(`TWE_SUB_ENABLE);
    chk(write_enabled, 1'b1);
    // Row loop: write a row, then, for every row after the first, read back the row before it and this one
    for (int i = 0; i < 4; i++) begin
      run({1'b1, `TWE_OP_WRITE, rows[i]}, 29, 1'b1);
      if (i > 0) begin
        run({1'b1, `TWE_OP_READ, rows[i - 1][25:16], 34'h0}, 47, 1'b0);
        chk(rx[32:0], {1'b0, rows[i - 1][15:0], rows[i][15:0]});
      end
    end
    special(`TWE_SUB_DISABLE);
    chk(write_enabled, 1'b0);
    run({1'b1, `TWE_OP_WRITE, 10'h000, 16'h1111}, 29, 1'b0);
    chk(prog_busy, 1'b0);
    run({1'b1, `TWE_OP_READ, 10'h000, 34'h0}, 47, 1'b0);
    chk(rx[32:0], {1'b0, 16'hA5C3, 16'h0F0F});
    special(`TWE_SUB_ENABLE);
    run({1'b1, `TWE_OP_ERASE, 10'h001}, 13, 1'b1);
    run({1'b1, `TWE_OP_READ, 10'h001, 34'h0}, 47, 1'b0);
    chk(rx[32:0], {1'b0, 16'hFFFF, 16'h8001});
    run({1'b1, `TWE_OP_SPECIAL, `TWE_SUB_WRALL, 8'h00, 16'h5AA5}, 29, 1'b1);
    run({1'b1, `TWE_OP_READ, 10'h3FE, 34'h0}, 47, 1'b0);
    chk(rx[32:0], {1'b0, 16'h5AA5, 16'h5AA5});
    // Byte organisation: odd byte address is the high half
    org_select <= 1'b0;
    run({1'b1, `TWE_OP_WRITE, 11'h005, 8'h3C}, 22, 1'b1);
    run({1'b1, `TWE_OP_READ, 11'h004, 18'h0}, 32, 1'b0);
    chk(rx[16:0], {1'b0, 8'hA5, 8'h3C});
    org_select <= 1'b1;
    special(`TWE_SUB_ERALL);
    run({1'b1, `TWE_OP_WRITE, 10'h003, 16'h0000}, 29, 1'b0);
    // Select raised long after the cycle ended: no status
    repeat (200) @(posedge ref_clk);
    fork
      u_twe_host.hold_cs(10);
      begin
        repeat (8) @(negedge ref_clk);
        chk(serial_out_oe_n, 1'b1);
      end
    join
    run({1'b1, `TWE_OP_READ, 10'h002, 34'h0}, 47, 1'b0);
    chk(rx[32:0], {1'b0, 16'hFFFF, 16'h0000});
    // Frame cut inside the data field must program nothing
    run({1'b1, `TWE_OP_WRITE, 10'h002, 7'h00}, 20, 1'b0);
    chk(prog_busy, 1'b0);
    // Mid-run reset clears the latch; a command inside the hold-off is refused
    rst <= 1'b1;
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    @(negedge ref_clk);
    chk(write_enabled, 1'b0);
    special(`TWE_SUB_ENABLE);
    chk(write_enabled, 1'b0);
    repeat (1000) @(posedge ref_clk);
    special(`TWE_SUB_ENABLE);
    chk(write_enabled, 1'b1);
    wrap_up();
  end
endmodule

// File: tb/twe_core_chk.sv
// Purpose: Port checks of the command logic
// Assumes: One clock domain, synchronous reset
// Notes:   Pin lag of the synchronisers allowed for in windows
module twe_core_chk #(
  parameter PROG_US = 3000,
  parameter POR_US  = 1
) (
  input wire ref_clk,
  input wire rst,
  input wire chip_select,
  input wire serial_clock,
  input wire serial_in,
  input wire org_select,
  input wire serial_out,
  input wire serial_out_oe_n,
  input wire prog_busy,
  input wire write_enabled
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  int busy_cnt;
  // Length of the running busy stretch
  always @(posedge ref_clk) busy_cnt <= (rst || !prog_busy) ? 0 : busy_cnt + 1;
  reset_state_a: assert property (disable iff (1'b0)
    rst |=> !prog_busy && !write_enabled && serial_out_oe_n)
    else $error("reset state wrong");
  busy_bound_a: assert property (prog_busy |-> busy_cnt < PROG_US * 10 + 2)
    else $error("busy too long");
  busy_enable_a: assert property ($rose(prog_busy) |-> write_enabled)
    else $error("program while disabled");
  latch_hold_a: assert property ($changed(write_enabled) |-> $past(chip_select, 5))
    else $error("latch moved outside a command");
  pin_release_a: assert property (!chip_select [*6] |-> serial_out_oe_n)
    else $error("pin not released");
  busy_low_a: assert property (
    prog_busy && !serial_out_oe_n && !$past(serial_out_oe_n) |-> !serial_out)
    else $error("busy not low");
  ready_high_a: assert property (
    $fell(prog_busy) && !serial_out_oe_n |-> ##[0:3] serial_out)
    else $error("ready not shown");
  status_select_a: assert property (
    $rose(chip_select) && prog_busy |-> ##[2:6] !serial_out_oe_n)
    else $error("no status");
  out_steady_a: assert property (
    (!$rose(serial_clock) && chip_select && !prog_busy) [*7] |-> $stable(serial_out))
    else $error("output moved off clock");
  cover property ($fell(prog_busy) && !serial_out_oe_n);
  cover property ($rose(write_enabled));
  cover property ($fell(write_enabled));
endmodule
bind twe_core twe_core_chk #(.PROG_US(PROG_US), .POR_US(POR_US)) u_twe_core_chk (
  .ref_clk(ref_clk), .rst(rst), .chip_select(chip_select), .serial_clock(serial_clock),
  .serial_in(serial_in), .org_select(org_select), .serial_out(serial_out),
  .serial_out_oe_n(serial_out_oe_n), .prog_busy(prog_busy), .write_enabled(write_enabled)
);

// File: tb/twe_host.sv
// Purpose: Host side of the three-wire link, frames and status polls
// Assumes: serial_clock period of 8 ref_clk cycles, 800 ns
// Notes:   Clock stands low between frames
module twe_host (
  input  wire  ref_clk,
  input  wire  data_line,
  output logic chip_select,
  output logic serial_clock,
  output logic serial_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    chip_select = 1'b0;
    serial_clock = 1'b0;
    serial_in = 1'b0;
  end
  // Whole frame, MSB first, don't-care bits included
  task automatic frame(input logic [63:0] bits, input int n, output logic [63:0] rx);
    rx = '0;
    @(posedge ref_clk) chip_select <= 1'b1;
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge ref_clk) serial_in <= bits[i];
      repeat (3) @(posedge ref_clk);
      // Output stands until this rise, so sample just before it
      rx = {rx[62:0], data_line};
      @(posedge ref_clk) serial_clock <= 1'b1;
      repeat (3) @(posedge ref_clk);
      serial_clock <= 1'b0;
    end
    repeat (3) @(posedge ref_clk);
    chip_select <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask
  // Select again after cs_low_time, wait for ready, bounded
  task automatic poll(output logic first, output int waited);
    @(posedge ref_clk) chip_select <= 1'b1;
    repeat (6) @(posedge ref_clk);
    first = data_line;
    waited = 0;
    while (data_line !== 1'b1 && waited < 300) begin
      waited++;
      @(posedge ref_clk);
    end
    chip_select <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask
  // Select without clocking, for a late status request
  task automatic hold_cs(input int n);
    @(posedge ref_clk) chip_select <= 1'b1;
    repeat (n) @(posedge ref_clk);
    chip_select <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask
endmodule
